// ### inc/crc_params.svh
// constants for the crc32 word calculator
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH
`define CRC_OFS_DATA     8'h00
`define CRC_OFS_SCRATCH  8'h04
`define CRC_OFS_CONTROL  8'h08
`define CRC_DATA_RESET   32'hffffffff
`define CRC_SCRATCH_RST  8'h00
`define CRC_POLY         32'h04c11db7
`define CRC_RESTART_BIT  0
`define CRC_CALC_NS      20
`define CRC_CLK_NS       5
`define CRC_CALC_CYCLES  ((`CRC_CALC_NS) / (`CRC_CLK_NS))
`define CRC_CNT_W        3
`define CRC_WORD_W       32
`define CRC_SCRATCH_W    8
`define CRC_RSVD_W       24
`endif

// ### inc/crc_pkg.sv
// types for the crc32 word calculator
package crc_pkg;
	typedef struct packed {
		logic        sel;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} crc_req_type;
	typedef struct packed {
		logic        ready;
		logic [31:0] rdata;
	} crc_rsp_type;
	typedef enum logic [1:0] {
		CRC_IDLE = 2'b01,
		CRC_BUSY = 2'b10
	} crc_state_type;
endpackage : crc_pkg

// ### tb/crc_master_model.sv
// crc bus master model
`timescale 1ns/1ps
`default_nettype none
module crc_master_model (
	input  wire logic                 clk,
	input  wire crc_pkg::crc_rsp_type rsp,
	output var  crc_pkg::crc_req_type req
);
	localparam int WAIT_LIMIT = 16;
	logic [31:0] r;
	logic        late;
	initial begin
		req  = '0;
		r    = '0;
		late = 1'b0;
	end
	// called 1 ns after a rising edge; the request stands until ready
	task automatic acc(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		req = '{sel: 1'b1, write: w, addr: a, wdata: d};
		#1;
		while (rsp.ready !== 1'b1 && n < WAIT_LIMIT) begin
			@(posedge clk);
			#2;
			n++;
		end
		late = late || (n >= WAIT_LIMIT);
		// ready and data settle mid-cycle and stand through the edge
		r = late ? 'x : rsp.rdata;
		@(posedge clk);
		#1;
	endtask : acc
	// drop the request and let one edge pass idle
	task automatic rel;
		req = '0;
		@(posedge clk);
		#1;
	endtask : rel
endmodule : crc_master_model
`default_nettype wire

// ### tb/crc_word_calc_monitor.sv
// crc checker
`timescale 1ns/1ps
`default_nettype none
`include "crc_params.svh"
module crc_word_calc_monitor (
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire crc_pkg::crc_req_type req,
	input wire crc_pkg::crc_rsp_type rsp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_busy_hold;
		req.sel && rsp.ready && req.write &&
		req.addr == `CRC_OFS_DATA
		|=> (!rsp.ready)[*3] ##1 rsp.ready;
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("data write not stalled for three cycles");
	property p_ready_idle;
		rsp.ready && !(req.sel && req.write &&
		req.addr == `CRC_OFS_DATA) |=> rsp.ready;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("stall without a data write");
	property p_reset_value;
		$past(!rstn) && req.sel && !req.write &&
		req.addr == `CRC_OFS_DATA |-> rsp.rdata == `CRC_DATA_RESET;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("data register not all ones after reset");
	property p_restart;
		req.sel && rsp.ready && req.write &&
		req.addr == `CRC_OFS_CONTROL && req.wdata[`CRC_RESTART_BIT]
		##1 req.sel && !req.write && req.addr == `CRC_OFS_DATA
		|-> rsp.rdata == `CRC_DATA_RESET;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart did not reload all ones");
	property p_scratch_high;
		req.sel && req.addr == `CRC_OFS_SCRATCH
		|-> rsp.rdata[`CRC_WORD_W-1:`CRC_SCRATCH_W] == '0;
	endproperty
	a_scratch_high: assert property (p_scratch_high)
		else $error("scratch reserved bits not zero");
	property p_control_zero;
		req.sel && req.addr == `CRC_OFS_CONTROL |-> rsp.rdata == '0;
	endproperty
	a_control_zero: assert property (p_control_zero)
		else $error("control register not read as zero");
	c_write: cover property (req.sel && rsp.ready && req.write &&
		req.addr == `CRC_OFS_DATA);
	c_restart: cover property (req.sel && rsp.ready &&
		req.addr == `CRC_OFS_CONTROL && req.wdata[`CRC_RESTART_BIT]);
	c_scratch: cover property (req.sel && rsp.ready &&
		req.addr == `CRC_OFS_SCRATCH);
endmodule : crc_word_calc_monitor
bind crc_word_calc crc_word_calc_monitor mon (.clk(clk), .rstn(rstn),
	.req(req), .rsp(rsp));
`default_nettype wire

// ### tb/crc_word_calc_test.sv
// crc testbench
`timescale 1ns/1ps
`default_nettype none
module crc_word_calc_test;
	logic	clk = 0, rstn = 0;
	crc_pkg::crc_req_type	req;
	crc_pkg::crc_rsp_type	rsp;
	int	mismatches = 0, n_tests = 0;
	crc_word_calc dut (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp));
	crc_master_model m (.clk(clk), .rsp(rsp), .req(req));
	function automatic logic [31:0] fold(logic [31:0] c);
		repeat (32) c = {c[30:0], 1'b0} ^ (c[31] ? 32'h04c11db7 : '0);
		return c;
	endfunction : fold
	task chk(string s, logic [31:0] g, e);
		n_tests++;
		mismatches += (g !== e);
		if (g !== e) $display("mismatch %s %h %h", s, e, g);
	endtask : chk
	task end_sim;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	initial forever #2.5 clk = ~clk;
	task t_reset_values;
		m.acc(1'b0, 8'h00, 32'h0);
		chk("data_reset", m.r, 32'hffffffff);
		m.acc(1'b0, 8'h04, 32'h0);
		chk("scratch_reset", m.r, 32'h0);
		m.acc(1'b0, 8'h08, 32'h0);
		chk("control_read", m.r, 32'h0);
	endtask : t_reset_values
	task t_stream;
		logic [31:0] e;
		logic [31:0] e1;
		e = fold(fold(32'hffffffff ^ 32'h12345678) ^ 32'hcafef00d);
		e1 = fold(32'hffffffff ^ 32'h12345678);
		m.acc(1'b1, 8'h00, 32'h12345678);
		m.acc(1'b1, 8'h00, 32'hcafef00d);
		m.acc(1'b0, 8'h00, 32'h0);
		chk("fold_two_words", m.r, e);
		m.acc(1'b1, 8'h08, 32'h0);
		m.acc(1'b0, 8'h00, 32'h0);
		chk("zero_control_write", m.r, e);
		m.acc(1'b1, 8'h04, 32'h000000a5);
		m.acc(1'b1, 8'h08, 32'h1);
		m.acc(1'b0, 8'h00, 32'h0);
		chk("restart_data", m.r, 32'hffffffff);
		m.acc(1'b0, 8'h04, 32'h0);
		chk("scratch_kept", m.r, 32'h000000a5);
		m.acc(1'b1, 8'h00, 32'h12345678);
		m.acc(1'b0, 8'h00, 32'h0);
		chk("fold_after_restart", m.r, e1);
	endtask : t_stream
	task t_mid_reset;
		m.acc(1'b1, 8'h04, 32'h0000003c);
		m.acc(1'b1, 8'h00, 32'h0badf00d);
		m.rel;
		rstn = 0;
		repeat (2) @(posedge clk);
		#1 rstn = 1;
		m.acc(1'b0, 8'h00, 32'h0);
		chk("data_after_reset", m.r, 32'hffffffff);
		m.acc(1'b0, 8'h04, 32'h0);
		chk("scratch_after_reset", m.r, 32'h0);
	endtask : t_mid_reset
	initial begin
		#8.5 rstn = 1;
		t_reset_values;
		t_stream;
		t_mid_reset;
		m.rel;
		if (m.late) mismatches++;
		end_sim;
	end
endmodule : crc_word_calc_test
`default_nettype wire

// ### verilog/crc_word_calc.sv
// crc32 word calculator with register interface
`timescale 1ns/1ps
`default_nettype none
`include "crc_params.svh"

// Contract
// - data write feeds calculator; read returns result
// - whole 32-bit word folded per write
// - writes stalled until computation finishes
// - restart loads all ones, scratch untouched
// - data register resets to all ones
// - scratch byte in bits 7:0, reset zero
// - restart leaves scratch byte unchanged
// - restart bit write-one, self clearing
// - fixed Ethernet polynomial 0x04c11db7
// - computation finishes within four cycles
module crc_word_calc (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire crc_pkg::crc_req_type req,
	output var  crc_pkg::crc_rsp_type rsp
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	// register state
	crc_pkg::crc_state_type      state;
	logic [`CRC_WORD_W-1:0]      checksum;
	logic [`CRC_WORD_W-1:0]      pending;
	logic [`CRC_SCRATCH_W-1:0]   scratch;
	logic [`CRC_CNT_W-1:0]       cnt;

	// fold chain, one word per stage boundary
	logic [`CRC_WORD_W-1:0]      foldStage [0:`CRC_WORD_W];

	// decode
	logic                        accData;
	logic                        accScratch;
	logic                        accControl;
	logic                        stall;
	logic                        dataWrite;
	logic                        scratchWrite;
	logic                        restart;
	logic                        engineLast;

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	assign accData      = req.sel && req.addr == `CRC_OFS_DATA;
	assign accScratch   = req.sel && req.addr == `CRC_OFS_SCRATCH;
	assign accControl   = req.sel && req.addr == `CRC_OFS_CONTROL;
	// any access during a computation waits: a read must see the result
	assign stall        = (state == crc_pkg::CRC_BUSY);
	assign dataWrite    = accData && req.write && !stall;
	assign scratchWrite = accScratch && req.write && !stall;
	// only a one in the restart bit acts; a zero write is ignored
	assign restart      = accControl && req.write && !stall &&
		req.wdata[`CRC_RESTART_BIT];
	assign engineLast   = (state == crc_pkg::CRC_BUSY) &&
		(cnt == `CRC_CNT_W'(1));

	// ------------------------------------------------------------
	// fold of one word: one shift stage per bit, msb first
	// ------------------------------------------------------------
	// whole word in one pass; depth traded for a one-cycle fold
	assign foldStage[0] = checksum ^ req.wdata;
	for (genvar i = 0; i < `CRC_WORD_W; i++) begin : g_fold
		logic                   msbOut;
		logic [`CRC_WORD_W-1:0] shifted;
		logic [`CRC_WORD_W-1:0] taps;
		assign msbOut  = foldStage[i][`CRC_WORD_W-1];
		assign shifted = {foldStage[i][`CRC_WORD_W-2:0], 1'b0};
		assign taps    = {`CRC_WORD_W{msbOut}} & `CRC_POLY;
		assign foldStage[i+1] = shifted ^ taps;
	end

	// ------------------------------------------------------------
	// sequencer: fixed latency models the multi-cycle engine
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= crc_pkg::CRC_IDLE;
		end else begin
			case (state)
			crc_pkg::CRC_IDLE: begin
				if (dataWrite) begin
					state <= crc_pkg::CRC_BUSY;
				end else begin
					state <= crc_pkg::CRC_IDLE;
				end
			end
			crc_pkg::CRC_BUSY: begin
				if (cnt == `CRC_CNT_W'(1)) begin
					state <= crc_pkg::CRC_IDLE;
				end else begin
					state <= crc_pkg::CRC_BUSY;
				end
			end
			default: begin
				state <= crc_pkg::CRC_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// latency counter
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt <= '0;
		end else if (dataWrite) begin
			cnt <= `CRC_CNT_W'(`CRC_CALC_CYCLES - 1);
		end else if (cnt != '0) begin
			cnt <= cnt - `CRC_CNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// pending result of the word in flight
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pending <= `CRC_DATA_RESET;
		end else if (restart) begin
			pending <= `CRC_DATA_RESET;
		end else if (dataWrite) begin
			pending <= foldStage[`CRC_WORD_W];
		end
	end

	// ------------------------------------------------------------
	// checksum, visible only once the engine is done
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			checksum <= `CRC_DATA_RESET;
		end else if (restart) begin
			checksum <= `CRC_DATA_RESET;
		end else if (engineLast) begin
			checksum <= pending;
		end
	end

	// ------------------------------------------------------------
	// scratch byte, untouched by restart
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			scratch <= `CRC_SCRATCH_RST;
		end else if (scratchWrite) begin
			// restart has no path here: the byte survives it
			scratch <= req.wdata[`CRC_SCRATCH_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// read data and ready
	// ------------------------------------------------------------
	always_comb begin
		rsp.ready = !stall;
		rsp.rdata = '0;
		if (req.sel) begin
			case (req.addr)
			`CRC_OFS_DATA: begin
				rsp.rdata = checksum;
			end
			`CRC_OFS_SCRATCH: begin
				rsp.rdata = {{`CRC_RSVD_W{1'b0}}, scratch};
			end
			`CRC_OFS_CONTROL: begin
				// restart bit clears itself at once, reads as zero
				rsp.rdata = '0;
			end
			default: begin
				// unmapped offsets read as zero
				rsp.rdata = '0;
			end
			endcase
		end
	end

endmodule : crc_word_calc
`default_nettype wire
